// ===== isw_defs.vh
// Constants for the interrupt, sleep and watchdog control block.
`ifndef ISW_DEFS_VH
`define ISW_DEFS_VH
// Byte addresses on the register bus.
`define ISW_ADDR_POWER_CONTROL_REG      12'h020
`define ISW_ADDR_WAKE      12'h024
`define ISW_ADDR_IEN       12'h038
`define ISW_ADDR_IFLAG     12'h03C
`define ISW_ADDR_OPTION    12'h040
`define ISW_ADDR_STATUS    12'h044
`define ISW_ADDR_DIR       12'h048
`define ISW_ADDR_CFG       12'h04C
// Field positions.
`define ISW_POWER_CONTROL_REG_WDTEN     7
`define ISW_POWER_CONTROL_REG_EXTPIN    6
`define ISW_OPT_EDGE       6
`define ISW_OPT_ASSIGN     3
`define ISW_IEN_GLOBAL     7
`define ISW_IRQ_TIMER      0
`define ISW_IRQ_PORT       1
`define ISW_IRQ_EXT        2
`define ISW_STAT_TO        4
`define ISW_STAT_PD        3
// Reset values.
`define ISW_POWER_CONTROL_REG_RST       8'hA0
`define ISW_OPTION_RST     8'h3F
`define ISW_DIR_RST        8'hFF
`define ISW_PRESC_RST      8'hFF
// Vectors.
`define ISW_VEC_IRQ        10'h008
`define ISW_VEC_SWI        10'h002
// Clock-oscillator modes in the configuration register.
`define ISW_MODE_HF        3'h0
`define ISW_MODE_LF        3'h1
`define ISW_MODE_XT        3'h2
`define ISW_MODE_IRC       3'h3
`define ISW_MODE_EXT_RES_INT_CAP_MODE      3'h4
`define ISW_MODE_ERC       3'h5
// Times in microseconds, clock in MHz.
`define ISW_CLK_MHZ        125
`define ISW_T_RC_US        650
`define ISW_T_18MS_US      18000
`define ISW_T_4MS5_US      4500
`define ISW_T_288MS_US     288000
`define ISW_T_72MS_US      72000
`endif

// ===== isw_prescaler.v
// Shared 8-bit down-counting prescaler for timer or watchdog.
`timescale 1ns/1ps
module isw_prescaler (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       clear,
    input  wire       tick,
    input  wire [3:0] ratio,
    output reg        pulse
);
`include "isw_defs.vh"
    reg  [7:0] count;
    wire [7:0] reload;
    // Ratio 0 means 1:1, then doubling; count reloads to 2**ratio-1, starting from all ones.
    assign reload = (8'hFF >> (4'h8 - ratio));

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= `ISW_PRESC_RST;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (clear) begin
                count <= `ISW_PRESC_RST;
            end else if (tick) begin
                if (count == 8'h00 || count > reload) begin
                    count <= reload;
                    pulse <= 1'b1;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end
endmodule // isw_prescaler

// ===== isw_wait_timer.v
// Wake-up start-up wait counter.
`timescale 1ns/1ps
module isw_wait_timer (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        start,
    input  wire [31:0] cycles,
    output wire        busy,
    output reg         done
);
    reg [31:0] remain;
    assign busy = (remain != 32'h0);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain <= 32'h0;
            done   <= 1'b0;
        end else begin
            done <= (remain == 32'h1);
            if (start) begin
                remain <= cycles;
            end else if (busy) begin
                remain <= remain - 32'h1;
            end
        end
    end
endmodule // isw_wait_timer

// ===== isw_control.v
// Interrupt, sleep, watchdog and reset-cause control with an AHB-Lite register slave.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module isw_control #(
    parameter [31:0] CYC_18MS  = 32'd2250000,
    parameter [31:0] CYC_4MS5  = 32'd562500,
    parameter [31:0] CYC_288MS = 32'd36000000,
    parameter [31:0] CYC_72MS  = 32'd9000000,
    parameter [31:0] CYC_RC    = 32'd81250
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        power_on_n,
    input  wire        low_voltage,
    input  wire        external_reset_pin_n,
    input  wire        clear_watchdog_instr,
    input  wire        sleep_instr,
    input  wire        return_from_irq_instr,
    input  wire        soft_irq_instr,
    input  wire        timer_write_instr,
    input  wire        timer_rollover,
    input  wire        port_b_access,
    input  wire        ext_irq_pin,
    input  wire [7:0]  port_b_in,
    input  wire        watchdog_osc_tick,
    output wire        timer_tick,
    output reg         vector_valid,
    output reg  [9:0]  vector_addr,
    output reg         device_reset,
    output reg         asleep,
    output wire        osc_stop,
    output wire        pins_hold,
    output wire        core_stall
);
`include "isw_defs.vh"
    // Clock-cycle counts derived from times.
    localparam [31:0] RC_CYC = `ISW_T_RC_US * `ISW_CLK_MHZ;

    // ************************************************************
    // Registers
    // ************************************************************
    reg  [7:0]  power_control_reg;
    reg  [7:0]  wake_select_reg;
    reg  [7:0]  irq_enable_reg;
    reg  [2:0]  irq_flags;
    reg  [7:0]  option_reg;
    reg  [7:0]  port_dir;
    reg  [4:0]  cfg_reg;
    reg         timeout_flag_n;
    reg         powerdown_flag_n;
    reg  [31:0] wd_count;
    reg         ext_s1, ext_s2, ext_prev;
    reg  [7:0]  pb_s1, pb_s2, pb_ref;
    reg         req_valid;
    reg         req_write;
    reg  [11:0] req_addr;
    reg         wake_pending_vec;
    reg         wd_fire;
    reg         rst_cause_wd;

    wire        global_irq_enable     = irq_enable_reg[`ISW_IEN_GLOBAL];
    wire        watchdog_enable_bit   = power_control_reg[`ISW_POWER_CONTROL_REG_WDTEN];
    wire        prescaler_assign_bit  = option_reg[`ISW_OPT_ASSIGN];
    wire [2:0]  prescaler_ratio_field = option_reg[2:0];
    wire        ext_edge_select       = option_reg[`ISW_OPT_EDGE];
    wire [1:0]  startup_time_select   = cfg_reg[1:0];
    wire [2:0]  osc_mode              = cfg_reg[4:2];
    wire        rc_mode = (osc_mode == `ISW_MODE_IRC) || (osc_mode == `ISW_MODE_EXT_RES_INT_CAP_MODE) ||
                          (osc_mode == `ISW_MODE_ERC);

    // ************************************************************
    // Bus slave
    // ************************************************************
    wire accept = hsel && hready && htrans[1];
    wire wr     = req_valid && req_write;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_valid <= 1'b0;
            req_write <= 1'b0;
            req_addr  <= 12'h000;
        end else begin
            req_valid <= accept;
            req_write <= hwrite;
            req_addr  <= haddr;
        end
    end

    // Read data is registered at the address phase so it stands in the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (accept && !hwrite) begin
            case (haddr)
                `ISW_ADDR_POWER_CONTROL_REG:   hrdata <= {24'h0, power_control_reg};
                `ISW_ADDR_WAKE:   hrdata <= {24'h0, wake_select_reg};
                `ISW_ADDR_IEN:    hrdata <= {24'h0, irq_enable_reg};
                `ISW_ADDR_IFLAG:  hrdata <= {29'h0, irq_flags & irq_enable_reg[2:0]};
                `ISW_ADDR_STATUS: hrdata <= {27'h0, timeout_flag_n, powerdown_flag_n, 3'h0};
                `ISW_ADDR_CFG:    hrdata <= {27'h0, cfg_reg};
                default:          hrdata <= 32'h0; // Option and direction are write-only.
            endcase
        end
    end

    // ************************************************************
    // Prescaler and watchdog
    // ************************************************************
    // A shared reset covers every source; the chip-level reset net is device_reset.
    wire wd_clear_evt = clear_watchdog_instr || sleep_instr;
    wire presc_clear  = device_reset ||
                        (prescaler_assign_bit ? wd_clear_evt : timer_write_instr);
    wire presc_tick   = prescaler_assign_bit ? watchdog_osc_tick : 1'b1;
    wire presc_pulse;
    wire [3:0] ratio  = prescaler_assign_bit ? {1'b0, prescaler_ratio_field}
                                             : {1'b0, prescaler_ratio_field} + 4'h1;

    isw_prescaler u_presc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (presc_clear),
        .tick    (presc_tick),
        .ratio   (ratio),
        .pulse   (presc_pulse)
    );

    assign timer_tick = !prescaler_assign_bit && presc_pulse;
    wire   wd_step    = prescaler_assign_bit ? presc_pulse : watchdog_osc_tick;

    reg [31:0] wd_limit;
    always @* begin
        case (startup_time_select)
            2'h0:    wd_limit = CYC_18MS;
            2'h1:    wd_limit = CYC_4MS5;
            2'h2:    wd_limit = CYC_288MS;
            default: wd_limit = CYC_72MS;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_count <= 32'h0;
            wd_fire  <= 1'b0;
        end else begin
            wd_fire <= 1'b0;
            if (wd_clear_evt || device_reset || !watchdog_enable_bit) begin
                wd_count <= 32'h0;
            end else if (wd_step) begin
                if (wd_count + 32'h1 >= wd_limit) begin
                    wd_count <= 32'h0;
                    wd_fire  <= 1'b1;
                end else begin
                    wd_count <= wd_count + 32'h1;
                end
            end
        end
    end

    // ************************************************************
    // Reset sources and reset-cause flags
    // ************************************************************
    wire ext_reset_evt = !power_on_n || low_voltage || !external_reset_pin_n;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            device_reset     <= 1'b1;
            rst_cause_wd     <= 1'b0;
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end else begin
            device_reset <= ext_reset_evt || wd_fire;
            rst_cause_wd <= wd_fire;
            if (!power_on_n || low_voltage) begin
                timeout_flag_n   <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end else if (wd_fire) begin
                timeout_flag_n <= 1'b0;
            end else if (sleep_instr) begin
                timeout_flag_n   <= 1'b1;
                powerdown_flag_n <= 1'b0;
            end else if (clear_watchdog_instr) begin
                timeout_flag_n   <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1   <= 1'b0;
            ext_s2   <= 1'b0;
            ext_prev <= 1'b0;
            pb_s1    <= 8'h00;
            pb_s2    <= 8'h00;
            pb_ref   <= 8'h00;
        end else begin
            ext_s1   <= ext_irq_pin;
            ext_s2   <= ext_s1;
            ext_prev <= ext_s2;
            pb_s1    <= port_b_in;
            pb_s2    <= pb_s1;
            if (port_b_access) begin
                pb_ref <= pb_s2;
            end
        end
    end

    wire ext_edge = ext_edge_select ? (ext_s2 && !ext_prev)
                                    : (!ext_s2 && ext_prev);
    wire ext_pin_mode = power_control_reg[`ISW_POWER_CONTROL_REG_EXTPIN];
    wire [7:0] pb_watch = wake_select_reg & port_dir & {7'h7F, !ext_pin_mode};
    wire port_change = |((pb_s2 ^ pb_ref) & pb_watch);

    // ************************************************************
    // Flags, enables and vectoring
    // ************************************************************
    wire [2:0] pending = irq_flags & irq_enable_reg[2:0];
    wire       take    = global_irq_enable && (|pending) && !asleep && !core_stall;
    wire       wake_evt = asleep && ((ext_edge && irq_enable_reg[`ISW_IRQ_EXT]) ||
                          (port_change && irq_enable_reg[`ISW_IRQ_PORT]));
    wire       wait_done;
    reg  [31:0] wait_cycles;

    always @* begin
        if (rc_mode) begin
            wait_cycles = CYC_RC;
        end else begin
            wait_cycles = wd_limit;
        end
    end

    isw_wait_timer u_wait (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (wake_evt),
        .cycles  (wait_cycles),
        .busy    (core_stall),
        .done    (wait_done)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_control_reg <= `ISW_POWER_CONTROL_REG_RST;
            wake_select_reg   <= 8'h00;
            irq_enable_reg    <= 8'h00;
            irq_flags         <= 3'h0;
            option_reg        <= `ISW_OPTION_RST;
            port_dir          <= `ISW_DIR_RST;
            cfg_reg           <= 5'h00;
            asleep            <= 1'b0;
            wake_pending_vec  <= 1'b0;
            vector_valid      <= 1'b0;
            vector_addr       <= 10'h000;
        end else begin
            vector_valid <= 1'b0;
            if (wr) begin
                case (req_addr)
                    `ISW_ADDR_POWER_CONTROL_REG:   power_control_reg <= hwdata[7:0];
                    `ISW_ADDR_WAKE:   wake_select_reg   <= hwdata[7:0];
                    `ISW_ADDR_IEN:    irq_enable_reg    <= {hwdata[7], 4'h0, hwdata[2:0]};
                    `ISW_ADDR_OPTION: option_reg        <= {1'b0, hwdata[6:0]};
                    `ISW_ADDR_DIR:    port_dir          <= hwdata[7:0];
                    `ISW_ADDR_CFG:    cfg_reg           <= hwdata[4:0];
                    default:          cfg_reg           <= cfg_reg;
                endcase
            end
            // Software clears flags by writing zeros; a same-cycle event still sets.
            irq_flags <= ((wr && req_addr == `ISW_ADDR_IFLAG) ? (irq_flags & hwdata[2:0])
                                                                 : irq_flags)
                       | {ext_edge,
                          port_change && irq_enable_reg[`ISW_IRQ_PORT],
                          timer_rollover};
            if (take) begin
                irq_enable_reg[`ISW_IEN_GLOBAL] <= 1'b0;
                vector_valid <= 1'b1;
                vector_addr  <= `ISW_VEC_IRQ;
            end else if (soft_irq_instr) begin
                vector_valid <= 1'b1;
                vector_addr  <= `ISW_VEC_SWI;
            end else if (return_from_irq_instr) begin
                irq_enable_reg[`ISW_IEN_GLOBAL] <= 1'b1;
            end
            if (sleep_instr) begin
                asleep <= 1'b1;
            end else if (wake_evt) begin
                wake_pending_vec <= global_irq_enable;
            end else if (wait_done) begin
                asleep           <= 1'b0;
                wake_pending_vec <= 1'b0;
            end
            if (device_reset) begin
                asleep <= 1'b0;
            end
        end
    end

    assign osc_stop  = asleep && !core_stall;
    assign pins_hold = asleep;
endmodule // isw_control

// ===== isw_chk_asserts.sv
// Concurrent checks on the ports of the interrupt, sleep and watchdog block.
`timescale 1ns/1ps
module isw_chk (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       low_voltage,
    input wire logic       external_reset_pin_n,
    input wire logic       sleep_instr,
    input wire logic       soft_irq_instr,
    input wire logic       vector_valid,
    input wire logic [9:0] vector_addr,
    input wire logic       device_reset,
    input wire logic       asleep,
    input wire logic       osc_stop,
    input wire logic       pins_hold,
    input wire logic       core_stall
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // **********************************************
    // Properties
    // **********************************************
    property p_swi_vec;
        soft_irq_instr && !device_reset |=> vector_valid && vector_addr == 10'h002;
    endproperty
    a_swi_vec: assert property (p_swi_vec) else $error("soft irq vector wrong");
    property p_vec_addr;
        vector_valid |-> vector_addr == 10'h008 || vector_addr == 10'h002;
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("bad vector");
    property p_vec_pulse;
        vector_valid |=> !vector_valid;
    endproperty
    a_vec_pulse: assert property (p_vec_pulse) else $error("vector not a pulse");
    property p_sleep_in;
        sleep_instr && !asleep && !device_reset |=> asleep;
    endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
    property p_hold;
        pins_hold == asleep && osc_stop == (asleep && !core_stall);
    endproperty
    a_hold: assert property (p_hold) else $error("oscillator or pins not held");
    property p_lv_rst;
        low_voltage |-> ##[1:2] device_reset;
    endproperty
    a_lv_rst: assert property (p_lv_rst) else $error("no brown-out reset");
    property p_pin_rst;
        !external_reset_pin_n |-> ##[1:2] device_reset;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("no pin reset");
    property p_wake;
        $fell(asleep) |-> $past(core_stall, 2) || device_reset || $past(device_reset);
    endproperty
    a_wake: assert property (p_wake) else $error("woke without start-up wait");
    property p_stall;
        core_stall |-> asleep;
    endproperty
    a_stall: assert property (p_stall) else $error("wait outside sleep");
    c_vec: cover property (vector_valid);
    c_wake: cover property ($fell(asleep));
    c_rst: cover property ($rose(device_reset));
endmodule // isw_chk

bind isw_control isw_chk isw_chk_i (.hclk(hclk), .hresetn(hresetn), .low_voltage(low_voltage),
    .external_reset_pin_n(external_reset_pin_n), .sleep_instr(sleep_instr),
    .soft_irq_instr(soft_irq_instr), .vector_valid(vector_valid), .vector_addr(vector_addr),
    .device_reset(device_reset), .asleep(asleep), .osc_stop(osc_stop), .pins_hold(pins_hold),
    .core_stall(core_stall));

// ===== isw_core_model.sv
// Processor core model that services a vector and returns from it.
`timescale 1ns/1ps
module isw_core_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic vector_valid,
    input  wire logic slow,
    output logic      return_from_irq_instr
);
    int cnt;
    // A slow service lets the bench see the global enable while it is cleared.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            return_from_irq_instr <= 1'b0;
        end else begin
            return_from_irq_instr <= (cnt == 1);
            if (vector_valid)
                cnt <= slow ? 40 : 3;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule // isw_core_model

// ===== test_irq_sleep_watchdog_control.sv
// Self-checking bench for the interrupt, sleep and watchdog block.
`timescale 1ns/1ps
module test_irq_sleep_watchdog_control;
    logic        hclk, hresetn, hsel, hwrite, ext_irq_pin, wd_tick, tick_on, slow, rfi;
    logic        hreadyout, timer_tick, vector_valid, device_reset, asleep, core_stall;
    logic        hresp, osc_stop, pins_hold;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd, d;
    logic [8:0]  ev;
    logic [7:0]  port_b_in;
    logic [9:0]  vector_addr;
    int          error_cnt = 0, checked = 0, n, v0, r0, vec_cnt = 0, rst_cnt = 0, tt_cnt = 0;

    isw_control #(.CYC_18MS(32'h14), .CYC_4MS5(32'h14), .CYC_288MS(32'h14), .CYC_72MS(32'h14),
        .CYC_RC(32'hA)) isw_control_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .power_on_n(~ev[5]), .low_voltage(ev[7]),
        .external_reset_pin_n(~ev[6]), .clear_watchdog_instr(ev[0]), .sleep_instr(ev[1]),
        .return_from_irq_instr(rfi), .soft_irq_instr(ev[2]), .timer_write_instr(ev[4]),
        .timer_rollover(ev[3]), .port_b_access(ev[8]), .ext_irq_pin(ext_irq_pin),
        .port_b_in(port_b_in), .watchdog_osc_tick(wd_tick), .timer_tick(timer_tick),
        .vector_valid(vector_valid), .vector_addr(vector_addr), .device_reset(device_reset),
        .asleep(asleep), .osc_stop(osc_stop), .pins_hold(pins_hold), .core_stall(core_stall));
    isw_core_model isw_core_model_i (.hclk(hclk), .hresetn(hresetn),
        .vector_valid(vector_valid), .slow(slow), .return_from_irq_instr(rfi));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        wd_tick <= tick_on;
        vec_cnt <= vec_cnt + (vector_valid === 1'b1);
        rst_cnt <= rst_cnt + (device_reset === 1'b1);
        tt_cnt <= tt_cnt + (timer_tick === 1'b1);
    end
    // **********************************************
    // Bench tasks
    // **********************************************
    function automatic logic [31:0] near(int v, int e, int t);
        return (v >= e - t && v <= e + t);
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task pulse(input int k);
        @(posedge hclk);
        ev <= 9'h1 << k;
        @(posedge hclk);
        ev <= 9'h0;
    endtask
    task wait_vec(input logic [9:0] a);
        n = 0;
        while (vector_valid !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        chk({21'h0, vector_valid, vector_addr}, {21'h0, 1'b1, a});
    endtask
    task print_verdict;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // **********************************************
    // Stimulus
    // **********************************************
    initial begin
        {hresetn, hsel, hwrite, ext_irq_pin, tick_on, slow} = 6'h0;
        {haddr, htrans, hwdata, ev} = '0;
        rd = $urandom(77);
        port_b_in = $urandom;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, 12'h044, 32'h0);
        chk(rd & 32'h18, 32'h18);
        bus(0, 12'h100, 32'h0);
        chk(rd, 32'h0);
        d = $urandom & 32'hFF;
        bus(1, 12'h024, d);
        bus(0, 12'h024, 32'h0);
        chk(rd & 32'hFF, d);
        bus(1, 12'h040, 32'h40);
        bus(1, 12'h038, 32'h85);
        slow <= 1'b1;
        pulse(3);
        wait_vec(10'h008);
        bus(0, 12'h03C, 32'h0);
        chk(rd & 32'h7, 32'h1);
        bus(0, 12'h038, 32'h0);
        chk(rd & 32'h87, 32'h05);
        bus(1, 12'h03C, 32'h0);
        repeat (50) @(posedge hclk);
        bus(0, 12'h038, 32'h0);
        chk(rd & 32'h87, 32'h85);
        slow <= 1'b0;
        for (int e = 1; e >= 0; e--) begin
            bus(1, 12'h040, e ? 32'h40 : 32'h0);
            bus(1, 12'h03C, 32'h0);
            @(posedge hclk);
            ext_irq_pin <= e[0];
            wait_vec(10'h008);
            bus(1, 12'h03C, 32'h0);
            repeat (8) @(posedge hclk);
        end
        pulse(2);
        wait_vec(10'h002);
        repeat (8) @(posedge hclk);
        bus(1, 12'h038, 32'h80);
        bus(1, 12'h03C, 32'h0);
        v0 = vec_cnt;
        pulse(3);
        repeat (8) @(posedge hclk);
        bus(0, 12'h03C, 32'h0);
        chk(rd & 32'h7, 32'h0);
        bus(1, 12'h038, 32'h01);
        bus(0, 12'h03C, 32'h0);
        chk(rd & 32'h7, 32'h1);
        chk(vec_cnt - v0, 0);
        bus(1, 12'h038, 32'h81);
        wait_vec(10'h008);
        bus(1, 12'h03C, 32'h0);
        repeat (8) @(posedge hclk);
        bus(1, 12'h038, 32'h02);
        for (int w = 1; w >= 0; w--) begin
            bus(1, 12'h024, w ? 32'hFF : 32'h0);
            bus(1, 12'h03C, 32'h0);
            pulse(8);
            port_b_in <= port_b_in ^ 8'hFF;
            repeat (8) @(posedge hclk);
            bus(0, 12'h03C, 32'h0);
            chk(rd & 32'h7, w ? 32'h2 : 32'h0);
        end
        bus(1, 12'h038, 32'h04);
        v0 = vec_cnt;
        for (int m = 0; m < 2; m++) begin
            bus(1, 12'h04C, m ? 32'h0C : 32'h0);
            bus(1, 12'h040, ext_irq_pin ? 32'h0 : 32'h40);
            bus(1, 12'h03C, 32'h0);
            pulse(1);
            bus(0, 12'h044, 32'h0);
            chk(rd & 32'h18, 32'h10);
            chk({29'h0, osc_stop, pins_hold, hresp}, 32'h6);
            ext_irq_pin <= ~ext_irq_pin;
            n = 0;
            for (int i = 0; i < 300 && asleep !== 1'b0; i++) begin
                @(posedge hclk);
                n += (core_stall === 1'b1);
            end
            chk(near(n, m ? 11 : 21, 2), 32'h1);
            chk({29'h0, asleep, osc_stop, pins_hold}, 32'h0);
        end
        chk(vec_cnt - v0, 0);
        bus(1, 12'h038, 32'h0);
        for (int r = 0; r < 3; r++) begin
            bus(1, 12'h040, r);
            pulse(4);
            v0 = tt_cnt;
            repeat (64) @(posedge hclk);
            chk(near(tt_cnt - v0, 64 >> (r + 1), 1), 32'h1);
        end
        for (int k = 5; k < 8; k++) begin
            r0 = rst_cnt;
            pulse(k);
            repeat (4) @(posedge hclk);
            chk(rst_cnt > r0, 32'h1);
            bus(0, 12'h044, 32'h0);
            chk(rd & 32'h18, 32'h18);
        end
        for (int i = 0; i < 4; i++) begin
            bus(1, 12'h040, (i == 1) ? 32'h08 : (i == 2) ? 32'h09 : 32'h0);
            pulse(0);
            if (i == 3)
                pulse(1);
            r0 = rst_cnt;
            n = 0;
            tick_on <= 1'b1;
            while (rst_cnt == r0 && n < 200) begin
                @(posedge hclk);
                n++;
            end
            tick_on <= 1'b0;
            chk(near(n, (i == 2) ? 42 : 22, 3), 32'h1);
            repeat (4) @(posedge hclk);
            bus(0, 12'h044, 32'h0);
            chk(rd & 32'h18, (i == 3) ? 32'h0 : 32'h08);
        end
        bus(1, 12'h040, 32'h0);
        r0 = rst_cnt;
        tick_on <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            repeat ($urandom_range(15, 5)) @(posedge hclk);
            pulse(0);
        end
        chk(rst_cnt - r0, 0);
        bus(1, 12'h020, 32'h20);
        repeat (100) @(posedge hclk);
        chk(rst_cnt - r0, 0);
        tick_on <= 1'b0;
        print_verdict;
    end
    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end
endmodule // test_irq_sleep_watchdog_control
